// ---- solenoid_image_pkg.sv ----
// constants for the cyclic input image of the solenoid actuator node
package solenoid_image_pkg;

    // channel count, image width and synchroniser depth
    localparam int          CHANNELS    = 8;
    localparam int          IMAGE_W     = 32;
    localparam int          SYNC_STAGES = 2;

    // byte lanes of the image
    localparam int          OVERCUR_LSB  = 0;
    localparam int          OPEN_LOAD_LSB = 8;
    localparam int          PLUNGER_LSB  = 16;
    localparam int          FLAGS_LSB    = 24;

    // summary flag positions inside the flag byte
    localparam int          FLAG_DRV_STATUS  = 0;
    localparam int          FLAG_UNDERVOLT   = 1;
    localparam int          FLAG_SERIAL_ERR  = 2;
    localparam int          FLAG_PLUNGER     = 3;
    localparam int          FLAG_STRIKE      = 4;
    localparam int          FLAG_OPEN_LOAD   = 5;
    localparam int          FLAG_OVERCUR     = 6;
    localparam int          FLAG_THERMAL     = 7;

    // reset values
    localparam logic [31:0] IMAGE_RST = 32'h0000_0000;
    localparam logic        VALID_RST = 1'b0;

endpackage

// ---- pin_sync.sv ----
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    initial begin
        if (W < 1) begin
            $error("pin_sync: width must be at least one");
        end
    end

    // first stage is read only by the second stage
    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;

endmodule

// ---- solenoid_fault_status_image.sv ----
// builds the cyclic input image of fault vectors and summary flags
`timescale 1ns/100ps

// Summary of operation
// - overcurrent vector, one bit per channel
// - open load vector, one bit per channel
// - plunger movement vector, one bit per channel
// - single flag mirrors overall driver status
// - flag set on driver undervoltage
// - flag set on serial link errors
// - flag set on plunger fault, any channel
// - flag set when strike current missed anywhere
// - flag set on open load, any channel
// - flag set on overcurrent, any channel
// - flag set during driver thermal shutdown
// - image marked valid once cyclic exchange runs
// - healthy device reads all zero
module solenoid_fault_status_image #(
    parameter int CHANNELS = solenoid_image_pkg::CHANNELS
) (
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic [CHANNELS-1:0] overcurrent_i,
    input  wire logic [CHANNELS-1:0] open_load_i,
    input  wire logic [CHANNELS-1:0] plunger_motion_check_i,
    input  wire logic [CHANNELS-1:0] strike_miss_i,
    input  wire logic                driver_fault_i,
    input  wire logic                undervoltage_i,
    input  wire logic                thermal_shutdown_i,
    input  wire logic                serial_error_i,
    input  wire logic                cycle_strobe_i,
    input  wire logic                link_operate_i,
    output logic [31:0]              cyclic_input_image_o,
    output logic                     image_valid_o
);

    localparam int PIN_W = 4 * CHANNELS + 3;

    initial begin
        if (CHANNELS < 1 || CHANNELS > solenoid_image_pkg::CHANNELS) begin
            $error("solenoid_fault_status_image: channel count out of range");
        end
    end

    // widen a channel vector to a full image byte, unused bits read zero
    function automatic logic [7:0] to_byte(input logic [CHANNELS-1:0] v);
        logic [7:0] b;
        b = 8'h00;
        b[CHANNELS-1:0] = v;
        return b;
    endfunction

    // assemble image bytes; flag byte is computed from the vectors and the misc bits
    function automatic logic [31:0] build_image(
        input logic [7:0] oc,
        input logic [7:0] ol,
        input logic [7:0] pm,
        input logic [7:0] sm,
        input logic [3:0] misc
    );
        logic [31:0] img;
        logic [7:0]  fl;
        fl = 8'h00;
        fl[solenoid_image_pkg::FLAG_DRV_STATUS] = misc[0];
        fl[solenoid_image_pkg::FLAG_UNDERVOLT]  = misc[1];
        fl[solenoid_image_pkg::FLAG_SERIAL_ERR] = misc[3];
        fl[solenoid_image_pkg::FLAG_PLUNGER]    = |pm;
        fl[solenoid_image_pkg::FLAG_STRIKE]     = |sm;
        fl[solenoid_image_pkg::FLAG_OPEN_LOAD]  = |ol;
        fl[solenoid_image_pkg::FLAG_OVERCUR]    = |oc;
        fl[solenoid_image_pkg::FLAG_THERMAL]    = misc[2];
        img = solenoid_image_pkg::IMAGE_RST;
        img[solenoid_image_pkg::OVERCUR_LSB +: 8]   = oc;
        img[solenoid_image_pkg::OPEN_LOAD_LSB +: 8] = ol;
        img[solenoid_image_pkg::PLUNGER_LSB +: 8]   = pm;
        img[solenoid_image_pkg::FLAGS_LSB +: 8]     = fl;
        return img;
    endfunction

    // driver pins come from another domain
    logic [PIN_W-1:0]    pins_sync;
    logic [CHANNELS-1:0] oc_live;
    logic [CHANNELS-1:0] ol_live;
    logic [CHANNELS-1:0] pm_live;
    logic [CHANNELS-1:0] sm_live;
    logic [3:0]          misc_live;

    pin_sync #(
        .W (PIN_W)
    ) u_pin_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({thermal_shutdown_i, undervoltage_i, driver_fault_i,
                   strike_miss_i, plunger_motion_check_i, open_load_i, overcurrent_i}),
        .sync_o  (pins_sync)
    );

    // bit n of each vector is channel n+1
    always_comb begin
        oc_live   = pins_sync[0 +: CHANNELS];
        ol_live   = pins_sync[CHANNELS +: CHANNELS];
        pm_live   = pins_sync[2*CHANNELS +: CHANNELS];
        sm_live   = pins_sync[3*CHANNELS +: CHANNELS];
        misc_live = {serial_error_i, pins_sync[4*CHANNELS +: 3]};
    end

    // sticky holders: a fault shorter than one master cycle still reaches the image
    logic [CHANNELS-1:0] oc_hold_r;
    logic [CHANNELS-1:0] oc_hold_nxt;
    logic [CHANNELS-1:0] ol_hold_r;
    logic [CHANNELS-1:0] ol_hold_nxt;
    logic [CHANNELS-1:0] pm_hold_r;
    logic [CHANNELS-1:0] pm_hold_nxt;
    logic [CHANNELS-1:0] sm_hold_r;
    logic [CHANNELS-1:0] sm_hold_nxt;
    logic [3:0]          misc_hold_r;
    logic [3:0]          misc_hold_nxt;
    logic                take;

    assign take = cycle_strobe_i && link_operate_i;

    // set wins over the clear taken by a snapshot
    always_comb begin
        oc_hold_nxt   = (take ? '0 : oc_hold_r) | oc_live;
        ol_hold_nxt   = (take ? '0 : ol_hold_r) | ol_live;
        pm_hold_nxt   = (take ? '0 : pm_hold_r) | pm_live;
        sm_hold_nxt   = (take ? '0 : sm_hold_r) | sm_live;
        misc_hold_nxt = (take ? 4'h0 : misc_hold_r) | misc_live;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            oc_hold_r   <= '0;
            ol_hold_r   <= '0;
            pm_hold_r   <= '0;
            sm_hold_r   <= '0;
            misc_hold_r <= 4'h0;
        end else begin
            oc_hold_r   <= oc_hold_nxt;
            ol_hold_r   <= ol_hold_nxt;
            pm_hold_r   <= pm_hold_nxt;
            sm_hold_r   <= sm_hold_nxt;
            misc_hold_r <= misc_hold_nxt;
        end
    end

    // image and validity; image is frozen between snapshots for coherence
    logic [31:0] image_r;
    logic [31:0] image_nxt;
    logic        valid_r;
    logic        valid_nxt;

    always_comb begin
        image_nxt = image_r;
        valid_nxt = valid_r;
        if (take) begin
            image_nxt = build_image(to_byte(oc_hold_r | oc_live),
                                    to_byte(ol_hold_r | ol_live),
                                    to_byte(pm_hold_r | pm_live),
                                    to_byte(sm_hold_r | sm_live),
                                    misc_hold_r | misc_live);
        end
        if (!link_operate_i) begin
            valid_nxt = 1'b0;
        end else if (cycle_strobe_i) begin
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            image_r <= solenoid_image_pkg::IMAGE_RST;
            valid_r <= solenoid_image_pkg::VALID_RST;
        end else begin
            image_r <= image_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign cyclic_input_image_o = image_r;
    assign image_valid_o        = valid_r;

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_take;
        cycle_strobe_i && link_operate_i;
    endsequence

    sequence s_oc_settled;
        overcurrent_i[0] [*3];
    endsequence

    sequence s_thermal_settled;
        thermal_shutdown_i [*3];
    endsequence

    sequence s_serial_then_take;
        (serial_error_i && link_operate_i && !cycle_strobe_i) ##1 s_take;
    endsequence

    a_valid_drop: assert property (
        !link_operate_i |=> !image_valid_o)
        else $error("image valid while link not operating");

    a_valid_set: assert property (
        s_take |=> image_valid_o)
        else $error("image not valid after cycle exchange");

    a_image_frozen: assert property (
        !cycle_strobe_i |=> $stable(cyclic_input_image_o))
        else $error("image changed without a snapshot");

    a_oc_summary: assert property (
        (|cyclic_input_image_o[solenoid_image_pkg::OVERCUR_LSB +: 8]) ==
        cyclic_input_image_o[solenoid_image_pkg::FLAGS_LSB + solenoid_image_pkg::FLAG_OVERCUR])
        else $error("overcurrent summary disagrees with vector");

    a_ol_summary: assert property (
        (|cyclic_input_image_o[solenoid_image_pkg::OPEN_LOAD_LSB +: 8]) ==
        cyclic_input_image_o[solenoid_image_pkg::FLAGS_LSB + solenoid_image_pkg::FLAG_OPEN_LOAD])
        else $error("open load summary disagrees with vector");

    a_pm_summary: assert property (
        (|cyclic_input_image_o[solenoid_image_pkg::PLUNGER_LSB +: 8]) ==
        cyclic_input_image_o[solenoid_image_pkg::FLAGS_LSB + solenoid_image_pkg::FLAG_PLUNGER])
        else $error("plunger summary disagrees with vector");

    a_oc_channel_one: assert property (
        s_oc_settled ##0 s_take |=>
        cyclic_input_image_o[solenoid_image_pkg::OVERCUR_LSB])
        else $error("channel one overcurrent missing from bit zero");

    a_thermal_path: assert property (
        s_thermal_settled ##0 s_take |=>
        cyclic_input_image_o[solenoid_image_pkg::FLAGS_LSB + solenoid_image_pkg::FLAG_THERMAL])
        else $error("thermal shutdown not reported");

    a_serial_kept: assert property (
        s_serial_then_take |=>
        cyclic_input_image_o[solenoid_image_pkg::FLAGS_LSB + solenoid_image_pkg::FLAG_SERIAL_ERR])
        else $error("serial error lost before snapshot");

    a_serial_same: assert property (
        (serial_error_i and s_take) |=>
        cyclic_input_image_o[solenoid_image_pkg::FLAGS_LSB + solenoid_image_pkg::FLAG_SERIAL_ERR])
        else $error("serial error lost at snapshot edge");

    a_reset_clean: assert property (
        $fell(rst_i) |-> (cyclic_input_image_o == 32'h0000_0000) && !image_valid_o)
        else $error("image not clean after reset");

    a_upper_zero: assert property (
        CHANNELS == 8 ||
        cyclic_input_image_o[solenoid_image_pkg::OVERCUR_LSB + CHANNELS] == 1'b0)
        else $error("unused channel bit set");

endmodule

// ---- master_model.sv ----
// cyclic master model: runs the link, strobes takes, captures the image
`timescale 1ns/100ps
module master_model (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        operate_i,
    input  wire logic        take_i,
    input  wire logic [31:0] image_i,
    input  wire logic        valid_i,
    output logic             cycle_strobe_o,
    output logic             link_operate_o,
    output logic      [31:0] got_image_o,
    output logic             got_valid_o
);
    logic strobe_d_r;

    // requests change only on the falling edge, away from the sampling edge
    always @(negedge clock_i) begin
        cycle_strobe_o <= take_i & ~rst_i;
        link_operate_o <= operate_i & ~rst_i;
    end

    // answer lands one edge after the take edge; one driver per signal
    always @(posedge clock_i) begin
        if (rst_i) begin
            strobe_d_r  <= 1'b0;
            got_image_o <= 32'h0000_0000;
            got_valid_o <= 1'b0;
        end else begin
            strobe_d_r <= cycle_strobe_o;
            if (strobe_d_r) begin
                got_image_o <= image_i;
                got_valid_o <= valid_i;
            end
        end
    end
endmodule

// ---- solenoid_fault_status_image_tb.sv ----
// self-checking bench for the cyclic fault image
`timescale 1ns/100ps
module solenoid_fault_status_image_tb;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  oc = 8'h00, ol = 8'h00, pm = 8'h00, sm = 8'h00;
    logic        drv = 1'b0, uv = 1'b0, th = 1'b0, se = 1'b0;
    logic        oper = 1'b0, take_r = 1'b0;
    logic        strobe, link, valid, got_valid;
    logic [31:0] image, got_image;
    int          n_errors = 0, n_tests = 0, cycles = 0;

    initial begin
        forever #2 clock_i = ~clock_i;
    end

    solenoid_fault_status_image #(.CHANNELS(8)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .overcurrent_i(oc), .open_load_i(ol),
        .plunger_motion_check_i(pm), .strike_miss_i(sm), .driver_fault_i(drv),
        .undervoltage_i(uv), .thermal_shutdown_i(th), .serial_error_i(se),
        .cycle_strobe_i(strobe), .link_operate_i(link),
        .cyclic_input_image_o(image), .image_valid_o(valid));

    master_model i_master (
        .clock_i(clock_i), .rst_i(rst_i), .operate_i(oper), .take_i(take_r),
        .image_i(image), .valid_i(valid), .cycle_strobe_o(strobe),
        .link_operate_o(link), .got_image_o(got_image), .got_valid_o(got_valid));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task summarize;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // pins settle through the synchroniser before the take
    task take;
        repeat (4) @(negedge clock_i);
        take_r <= 1'b1;
        @(negedge clock_i);
        take_r <= 1'b0;
        repeat (3) @(negedge clock_i);
    endtask

    // sticky faults need one take to clear, the next one reads clean
    task clean;
        {oc, ol, pm, sm, drv, uv, th, se} <= '0;
        take();
        take();
        check(got_image, 32'h0000_0000);
        check({31'h0, got_valid}, {31'h0, oper});
    endtask

    task t_reset;
        check(image, 32'h0000_0000);
        check({31'h0, valid}, 32'h0000_0000);
    endtask

    // take refused while the link is down: valid stays low
    task t_refused;
        oper <= 1'b0;
        drv <= 1'b1;
        take();
        check({31'h0, valid}, 32'h0000_0000);
        check(image, 32'h0000_0000);
        oper <= 1'b1;
        clean();
    endtask

    task t_channels;
        logic [7:0] b, c;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            c = 8'h01 << ((i + 3) % 8);
            @(negedge clock_i);
            oc <= b; ol <= c; pm <= b; sm <= c;
            take();
            check(got_image, {8'h78, b, c, b});
            check({31'h0, got_valid}, 32'h0000_0001);
            clean();
        end
    endtask

    // single driver flags, serial error given as a one-cycle pulse
    task t_flags;
        for (int k = 0; k < 4; k++) begin
            @(negedge clock_i);
            case (k)
                0: drv <= 1'b1;
                1: uv <= 1'b1;
                2: th <= 1'b1;
                default: se <= 1'b1;
            endcase
            @(negedge clock_i);
            se <= 1'b0;
            take();
            case (k)
                0: check(got_image, 32'h0100_0000);
                1: check(got_image, 32'h0200_0000);
                2: check(got_image, 32'h8000_0000);
                default: check(got_image, 32'h0400_0000);
            endcase
            clean();
        end
    endtask

    // link drop clears valid but keeps the last image
    task t_link_drop;
        uv <= 1'b1;
        take();
        oper <= 1'b0;
        repeat (4) @(negedge clock_i);
        check({31'h0, valid}, 32'h0000_0000);
        check(image, 32'h0200_0000);
        oper <= 1'b1;
        clean();
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(negedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        t_reset();
        t_refused();
        t_channels();
        t_flags();
        t_link_drop();
        summarize();
    end
endmodule
